// ---- rtl/bic_defines.vh ----
`ifndef BIC_DEFINES_VH
`define BIC_DEFINES_VH
//
// Summary of operation
// - free read-write routing byte, unused by logic
// - pin selector: 0 none, 1-4 INTA-INTD
// - reset selector zero: no legacy interrupts
// - bit 0 gates poisoned TLP logging
// - bit 1 forwards secondary error messages upstream
// - reporting also needs command/device control enable
// - bit 2 sends ISA aliases upstream
// - bit 3 forwards VGA addresses downstream
// - bit 4 width select needs VGA forwarding
// - 10-bit decode aliases, 16-bit does not
// - bit 6 starts up/downstream secondary reset

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BIC_OFS_ROUTE      8'h3C
`define BIC_OFS_PIN        8'h3D
`define BIC_OFS_CTRL       8'h3E
`define BIC_OFS_EVT_STAT   8'h80
`define BIC_OFS_EVT_MASK   8'h82
`define BIC_OFS_STATE      8'h84

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define BIC_RST_ROUTE      8'h00
`define BIC_RST_PIN        8'h00
`define BIC_RST_CTRL       16'h0000
`define BIC_CTRL_WMASK     16'h005F
`define BIC_RST_EVT        3'h0

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define BIC_CTL_POISON_LOG 0
`define BIC_CTL_ERR_FWD    1
`define BIC_CTL_ISA        2
`define BIC_CTL_VGA        3
`define BIC_CTL_VGA16      4
`define BIC_CTL_SEC_RST    6

// ----------------------------------------------------------------
// event status fields
// ----------------------------------------------------------------
`define BIC_EVT_POISON     0
`define BIC_EVT_ERR_FWD    1
`define BIC_EVT_SEC_RST    2
`define BIC_EVT_W          3

// ----------------------------------------------------------------
// pin selector codes
// ----------------------------------------------------------------
`define BIC_PIN_NONE       8'h00
`define BIC_PIN_INTA       8'h01
`define BIC_PIN_INTB       8'h02
`define BIC_PIN_INTC       8'h03
`define BIC_PIN_INTD       8'h04

`endif

// ---- rtl/bic_route.v ----
`timescale 1ns/10ps
`include "bic_defines.vh"

module bic_route (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        req_valid,
  input  wire        req_is_io,
  input  wire [31:0] req_addr,
  input  wire        req_in_window,
  input  wire        isa_en,
  input  wire        vga_en,
  input  wire        vga_wide,
  output reg         route_valid,
  output reg         route_down,
  output reg         route_up
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire       low64k  = (req_addr[31:16] == 16'h0000);
  wire [9:0] a10     = req_addr[9:0];
  wire       isa_hit = req_is_io && low64k && (req_addr[9:8] != 2'h0);
  wire       isa_up  = isa_en && req_in_window && isa_hit;
  wire       vio10   = ((a10 >= 10'h3B0) && (a10 <= 10'h3BB)) ||
                       ((a10 >= 10'h3C0) && (a10 <= 10'h3DF));
  // 16-bit mode refuses the aliases above the first 1 KB
  wire       vio_ok  = vga_wide ? (low64k && req_addr[15:10] == 6'h00)
                                : 1'b1;
  wire       vio_hit = req_is_io && vio10 && vio_ok;
  wire       vmem    = !req_is_io && (req_addr[31:17] == 15'h0005);
  wire       vga_dn  = vga_en && (vio_hit || vmem);

  always @(posedge core_clk) begin
    if (rst) begin
      route_valid <= 1'b0;
      route_down  <= 1'b0;
      route_up    <= 1'b0;
    end else if (ce) begin
      route_valid <= req_valid;
      route_down  <= req_valid && (vga_dn || (req_in_window && !isa_up));
      route_up    <= req_valid && isa_up && !vga_dn;
    end
  end

endmodule // bic_route

// ---- rtl/bic_regs.v ----
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "bic_defines.vh"

module bic_regs (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata,
  output wire        irq,
  input  wire        is_downstream,
  input  wire        hotplug_event,
  output wire [3:0]  intx_out,
  output wire        legacy_msg_en,
  input  wire        poison_tlp,
  output wire        master_parity_error_flag,
  input  wire        sec_err_valid,
  input  wire [1:0]  sec_err_kind,
  input  wire        cmd_err_report_en,
  input  wire        devctl_err_report_en,
  output wire        err_fwd_valid,
  output wire [1:0]  err_fwd_kind,
  output wire        err_report_valid,
  output wire        sec_reset_active,
  output wire        sec_reset_up_start,
  output wire        sec_reset_down_start,
  input  wire        req_valid,
  input  wire        req_is_io,
  input  wire [31:0] req_addr,
  input  wire        req_in_window,
  output wire        route_valid,
  output wire        route_down,
  output wire        route_up
);

  // ----------------------------------------------------------------
  // pin selector decode
  // ----------------------------------------------------------------
  function [3:0] pin_onehot;
    input [7:0] sel;
    begin
      case (sel)
        `BIC_PIN_INTA: pin_onehot = 4'h1;
        `BIC_PIN_INTB: pin_onehot = 4'h2;
        `BIC_PIN_INTC: pin_onehot = 4'h4;
        `BIC_PIN_INTD: pin_onehot = 4'h8;
        default:       pin_onehot = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0]          route_byte_q;
  reg  [7:0]          pin_sel_q;
  reg  [15:0]         ctrl_q;
  reg  [`BIC_EVT_W-1:0] evt_stat_q;
  reg  [`BIC_EVT_W-1:0] evt_mask_q;
  reg  [15:0]         rdata_q;
  reg  [3:0]          intx_q;
  reg                 legacy_q;
  reg                 mpe_q;
  reg                 fwd_valid_q;
  reg  [1:0]          fwd_kind_q;
  reg                 report_q;
  reg                 srst_up_q;
  reg                 srst_dn_q;
  reg  [15:0]         rdata_d;
  wire [`BIC_EVT_W-1:0] evt_stat_d;
  reg  [15:0]         ctrl_d;

  wire wr_route = reg_wr && (reg_addr == `BIC_OFS_ROUTE);
  wire wr_pin   = reg_wr && (reg_addr == `BIC_OFS_PIN);
  wire wr_ctrl  = reg_wr && (reg_addr == `BIC_OFS_CTRL);
  wire wr_stat  = reg_wr && (reg_addr == `BIC_OFS_EVT_STAT);
  wire wr_mask  = reg_wr && (reg_addr == `BIC_OFS_EVT_MASK);

  wire poison_log = ctrl_q[`BIC_CTL_POISON_LOG];
  wire err_fwd_en = ctrl_q[`BIC_CTL_ERR_FWD];
  wire srst_bit   = ctrl_q[`BIC_CTL_SEC_RST];
  wire rpt_en     = cmd_err_report_en || devctl_err_report_en;

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire ev_poison = ce && poison_tlp && poison_log;
  wire ev_errfwd = ce && sec_err_valid && err_fwd_en;
  wire srst_rise = wr_ctrl && reg_wdata[`BIC_CTL_SEC_RST] && !srst_bit;
  wire ev_srst   = ce && srst_rise;
  wire [`BIC_EVT_W-1:0] ev_vec = {ev_srst, ev_errfwd, ev_poison};

  // ----------------------------------------------------------------
  // control word next value
  // ----------------------------------------------------------------
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata & `BIC_CTRL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `BIC_EVT_W; g = g + 1) begin : g_evt
      assign evt_stat_d[g] = ev_vec[g] || (evt_stat_q[g] && !(wr_stat && reg_wdata[g]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `BIC_OFS_ROUTE:    rdata_d = {8'h00, route_byte_q};
      `BIC_OFS_PIN:      rdata_d = {8'h00, pin_sel_q};
      `BIC_OFS_CTRL:     rdata_d = ctrl_q & `BIC_CTRL_WMASK;
      `BIC_OFS_EVT_STAT: rdata_d = {13'h0000, evt_stat_q};
      `BIC_OFS_EVT_MASK: rdata_d = {13'h0000, evt_mask_q};
      `BIC_OFS_STATE:    rdata_d = {14'h0000, srst_bit, is_downstream};
      default:           rdata_d = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      route_byte_q <= `BIC_RST_ROUTE;
      pin_sel_q    <= `BIC_RST_PIN;
      ctrl_q       <= `BIC_RST_CTRL;
      evt_stat_q   <= `BIC_RST_EVT;
      evt_mask_q   <= `BIC_RST_EVT;
      rdata_q      <= 16'h0000;
    end else if (ce) begin
      if (wr_route) begin
        route_byte_q <= reg_wdata[7:0];
      end
      if (wr_pin) begin
        pin_sel_q <= reg_wdata[7:0];
      end
      if (wr_mask) begin
        evt_mask_q <= reg_wdata[`BIC_EVT_W-1:0];
      end
      ctrl_q     <= ctrl_d;
      evt_stat_q <= evt_stat_d;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // legacy interrupt signalling
  // ----------------------------------------------------------------
  // values 0x2..0x4 decode faithfully; software keeps to 0x0/0x1
  always @(posedge core_clk) begin
    if (rst) begin
      intx_q   <= 4'h0;
      legacy_q <= 1'b0;
    end else if (ce) begin
      intx_q   <= (is_downstream && hotplug_event) ? pin_onehot(pin_sel_q)
                                                  : 4'h0;
      legacy_q <= (pin_onehot(pin_sel_q) != 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // poison logging and error forwarding
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      mpe_q       <= 1'b0;
      fwd_valid_q <= 1'b0;
      fwd_kind_q  <= 2'h0;
      report_q    <= 1'b0;
    end else if (ce) begin
      mpe_q       <= evt_stat_d[`BIC_EVT_POISON];
      fwd_valid_q <= sec_err_valid && err_fwd_en;
      fwd_kind_q  <= sec_err_kind;
      report_q    <= sec_err_valid && err_fwd_en && rpt_en;
    end
  end

  // ----------------------------------------------------------------
  // secondary bus reset
  // ----------------------------------------------------------------
  // port config stays writable; software refrains during reset
  always @(posedge core_clk) begin
    if (rst) begin
      srst_up_q <= 1'b0;
      srst_dn_q <= 1'b0;
    end else if (ce) begin
      srst_up_q <= srst_rise && !is_downstream;
      srst_dn_q <= srst_rise && is_downstream;
    end
  end

  // ----------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------
  bic_route u_route (
    .core_clk      (core_clk),
    .rst           (rst),
    .ce            (ce),
    .req_valid     (req_valid),
    .req_is_io     (req_is_io),
    .req_addr      (req_addr),
    .req_in_window (req_in_window),
    .isa_en        (ctrl_q[`BIC_CTL_ISA]),
    .vga_en        (ctrl_q[`BIC_CTL_VGA]),
    .vga_wide      (ctrl_q[`BIC_CTL_VGA16]),
    .route_valid   (route_valid),
    .route_down    (route_down),
    .route_up      (route_up)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata                = rdata_q;
  assign irq                      = |(evt_stat_q & evt_mask_q);
  assign intx_out                 = intx_q;
  assign legacy_msg_en            = legacy_q;
  assign master_parity_error_flag = mpe_q;
  assign err_fwd_valid            = fwd_valid_q;
  assign err_fwd_kind             = fwd_kind_q;
  assign err_report_valid         = report_q;
  assign sec_reset_active         = srst_bit;
  assign sec_reset_up_start       = srst_up_q;
  assign sec_reset_down_start     = srst_dn_q;

endmodule // bic_regs

// ---- tb/bic_regs_props.sv ----
`timescale 1ns/10ps
module bic_regs_props (
  input logic        core_clk,
  input logic        rst,
  input logic        ce,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic [7:0]  reg_addr,
  input logic        is_downstream,
  input logic        hotplug_event,
  input logic [3:0]  intx_out,
  input logic        poison_tlp,
  input logic        master_parity_error_flag,
  input logic        sec_err_valid,
  input logic [1:0]  sec_err_kind,
  input logic        cmd_err_report_en,
  input logic        devctl_err_report_en,
  input logic        err_fwd_valid,
  input logic [1:0]  err_fwd_kind,
  input logic        err_report_valid,
  input logic        sec_reset_active,
  input logic        sec_reset_up_start,
  input logic        sec_reset_down_start,
  input logic        req_valid,
  input logic        route_valid,
  input logic        route_up,
  input logic        route_down
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rdata_idle_zero: assert property ($past(!reg_rd && ce) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_ctrl_resv_zero: assert property (ce && reg_rd && reg_addr == 8'h3E |=> (reg_rdata & 16'hFFA0) == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_fwd_needs_msg: assert property (err_fwd_valid |-> $past(sec_err_valid) && err_fwd_kind == $past(sec_err_kind))
    else $error("error forwarded without message");
  a_report_needs_en: assert property (err_report_valid |-> err_fwd_valid && $past(cmd_err_report_en || devctl_err_report_en))
    else $error("error reported without enable");
  a_secondary_reset_trigger_start: assert property ((sec_reset_up_start || sec_reset_down_start) |-> sec_reset_active && !$past(sec_reset_active) && (sec_reset_down_start == $past(is_downstream)))
    else $error("secondary reset start wrong");
  a_parity_cause: assert property ($rose(master_parity_error_flag) |-> $past(poison_tlp))
    else $error("parity flag set without poisoned packet");
  a_route_cause: assert property (route_valid |-> $past(req_valid) && !(route_up && route_down))
    else $error("route result without request or both ways");
  a_intx_onehot: assert property ($onehot0(intx_out))
    else $error("more than one legacy line");
  a_intx_cause: assert property (intx_out != 4'h0 |-> $past(is_downstream && hotplug_event))
    else $error("legacy line without downstream event");
  c_report: cover property (err_report_valid);
  c_secondary_reset_trigger_up: cover property (sec_reset_up_start);
  c_route_up: cover property (route_up);
  c_intx: cover property (intx_out != 4'h0);
endmodule // bic_regs_props

// ---- tb/bic_far.sv ----
`timescale 1ns/10ps
module bic_far (
  input  logic       core_clk,
  output logic       poison_tlp,
  output logic       sec_err_valid,
  output logic [1:0] sec_err_kind
);
  initial begin
    poison_tlp = 1'b0;
    sec_err_valid = 1'b0;
    sec_err_kind = 2'h3;
  end
  // one-cycle poisoned packet or error message; idle kind shows inverse
  task send(input logic p, input logic [1:0] k);
    @(posedge core_clk);
    poison_tlp <= p;
    sec_err_valid <= !p;
    sec_err_kind <= k;
    @(posedge core_clk);
    poison_tlp <= 1'b0;
    sec_err_valid <= 1'b0;
    sec_err_kind <= ~k;
  endtask
endmodule // bic_far

// ---- tb/test_bic_regs.sv ----
`timescale 1ns/10ps
module test_bic_regs;
  logic        core_clk, rst, ce, reg_wr, reg_rd, irq, is_downstream, hotplug_event;
  logic        legacy_msg_en, poison_tlp, master_parity_error_flag, sec_err_valid;
  logic        cmd_err_report_en, devctl_err_report_en, err_fwd_valid, err_report_valid;
  logic        sec_reset_active, sec_reset_up_start, sec_reset_down_start;
  logic        req_valid, req_is_io, req_in_window, route_valid, route_down, route_up;
  logic [1:0]  sec_err_kind, err_fwd_kind;
  logic [3:0]  intx_out;
  logic [4:0]  e;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, k;
  logic [31:0] req_addr;
  logic [43:0] rt [10];
  int          n_fail, cmp_count, i;
  bic_regs bic_regs_inst (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .is_downstream, .hotplug_event, .intx_out, .legacy_msg_en, .poison_tlp,
    .master_parity_error_flag, .sec_err_valid, .sec_err_kind, .cmd_err_report_en,
    .devctl_err_report_en, .err_fwd_valid, .err_fwd_kind, .err_report_valid, .sec_reset_active,
    .sec_reset_up_start, .sec_reset_down_start, .req_valid, .req_is_io, .req_addr,
    .req_in_window, .route_valid, .route_down, .route_up);
  bic_far bic_far_inst (.core_clk, .poison_tlp, .sec_err_valid, .sec_err_kind);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] x);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  task test_done;
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
  initial begin
    {rst, ce} = 2'b11;
    {reg_wr, reg_rd, is_downstream, hotplug_event, cmd_err_report_en} = 5'h00;
    {devctl_err_report_en, req_valid, req_is_io, req_in_window} = 4'h0;
    {reg_addr, reg_wdata, req_addr} = 56'h0;
    rt = '{44'h04_00000100_6, 44'h04_00000000_5, 44'h00_00000100_5, 44'h08_000003C0_1,
           44'h00_000003C0_0, 44'h08_000007C0_1, 44'h18_000007C0_0, 44'h10_000003C0_0,
           44'h18_000003C0_1, 44'h04_00010100_5};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h3C, 16'h0000);
    rd(8'h3D, 16'h0000);
    rd(8'h3E, 16'h0000);
    rd(8'h80, 16'h0000);
    rd(8'h50, 16'h0000);
    wr(8'h3C, 16'h00A5);
    rd(8'h3C, 16'h00A5);
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h3C, 16'h005A);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(8'h3C, 16'h00A5);
    wr(8'h3E, 16'hFFFF);
    chk({14'h0, sec_reset_up_start, sec_reset_active}, 16'h0003);
    rd(8'h3E, 16'h005F);
    rd(8'h80, 16'h0004);
    wr(8'h3E, 16'h0000);
    for (i = 0; i < 8; i++) begin
      wr(8'h3E, {14'h0, i[1], 1'b0});
      cmd_err_report_en <= i[0];
      devctl_err_report_en <= i[2];
      bic_far_inst.send(1'b0, 2'h2);
      #1 chk({14'h0, err_fwd_valid, err_report_valid}, {14'h0, i[1], i[1] & (i[0] | i[2])});
      if (i[1]) chk({14'h0, err_fwd_kind}, 16'h0002);
    end
    wr(8'h80, 16'h0007);
    wr(8'h3E, 16'h0000);
    bic_far_inst.send(1'b1, 2'h0);
    rd(8'h80, 16'h0000);
    wr(8'h3E, 16'h0001);
    bic_far_inst.send(1'b1, 2'h0);
    #1 chk({14'h0, master_parity_error_flag, irq}, 16'h0002);
    rd(8'h80, 16'h0001);
    wr(8'h82, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    wr(8'h80, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    for (i = 0; i < 10; i++) begin
      wr(8'h3E, {8'h0, rt[i][43:36]});
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_is_io <= 1'b1;
      req_addr <= rt[i][35:4];
      req_in_window <= rt[i][2];
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1 chk({13'h0, route_valid, route_up, route_down}, {13'h0, 1'b1, rt[i][1:0]});
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h3E, 16'h0000);
    rd(8'h3C, 16'h0000);
    is_downstream <= 1'b1;
    hotplug_event <= 1'b1;
    for (k = 16'h0; k < 16'h5; k++) begin
      wr(8'h3D, k);
      rd(8'h3D, k);
      repeat (2) @(posedge core_clk);
      e = 5'h01 << k[2:0];
      #1 chk({11'h0, legacy_msg_en, intx_out}, {11'h0, k != 16'h0, e[4:1]});
    end
    wr(8'h3D, 16'h0001);
    wr(8'h3E, 16'h0040);
    chk({14'h0, sec_reset_down_start, sec_reset_up_start}, 16'h0002);
    rd(8'h84, 16'h0003);
    test_done();
  end
endmodule // test_bic_regs
bind bic_regs bic_regs_props bic_regs_props_inst (.core_clk, .rst, .ce, .reg_rd, .reg_rdata,
  .reg_addr, .is_downstream, .hotplug_event, .intx_out, .poison_tlp, .master_parity_error_flag,
  .sec_err_valid, .sec_err_kind, .cmd_err_report_en, .devctl_err_report_en, .err_fwd_valid,
  .err_fwd_kind, .err_report_valid, .sec_reset_active, .sec_reset_up_start,
  .sec_reset_down_start, .req_valid, .route_valid, .route_up, .route_down);
